// *** rtl/host_buffer_ram_access.sv ***
// Host buffer RAM access: region size, status flags, read-back counts, data ports
`timescale 1ns/1ps
`default_nettype none
module host_buffer_ram_access
  import buf_ram_pkg::*;
#(
  parameter int AW = 12
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  // Processor command/data port
  input  wire logic        cmd_stb,
  input  wire logic [7:0]  cmd_code,
  input  wire logic        wr_stb,
  input  wire logic [15:0] wr_data,
  input  wire logic        rd_stb,
  output logic      [15:0] rd_data,
  // Controller-side context
  input  wire logic [15:0] transfer_byte_counter,
  input  wire logic [15:0] iso_region_size,
  input  wire logic        iso_port_sel,
  input  wire logic [15:0] iso0_pending_bytes,
  input  wire logic [15:0] iso1_pending_bytes,
  input  wire logic [2:0]  engine_consumed,
  input  wire logic [2:0]  engine_filled,
  // Events and region size out
  output logic             all_transfers_done_flag,
  output logic      [15:0] ack_list_region_size
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    mode_t       mode;
    logic [7:0]  code;
    logic        iso_sel;
    logic [15:0] ptr;
    logic [15:0] rdata;
    logic [15:0] ack_len;
    logic [5:0]  flags;
    logic [15:0] rb0;
    logic [15:0] rb1;
    logic        eot;
  } state_t;

  state_t s_q, s_d;
  logic [7:0] ram_even [RAM_BYTES/2];
  logic [7:0] ram_odd  [RAM_BYTES/2];
  logic [AW-1:0] base, addr;
  logic [AW-2:0] widx;
  logic port_rd, port_wr, is_iso, access, at_end, fin, len_wr;

  // Region base of the buffer the current port command targets
  always_comb begin
    if (s_q.mode == M_ACK_RD || s_q.mode == M_ACK_WR) begin
      base = AW'({iso_region_size[14:0], 1'b0});
    end else if (s_q.iso_sel) begin
      base = iso_region_size[AW-1:0];
    end else begin
      base = '0;
    end
  end
  assign addr    = base + s_q.ptr[AW-1:0];
  assign widx    = addr[AW-1:1];
  assign is_iso  = (s_q.mode == M_ISO_RD || s_q.mode == M_ISO_WR);
  assign port_rd = (s_q.mode == M_ISO_RD || s_q.mode == M_ACK_RD) && rd_stb;
  assign port_wr = (s_q.mode == M_ISO_WR || s_q.mode == M_ACK_WR) && wr_stb;
  assign access  = port_rd || port_wr;
  assign at_end  = (s_q.ptr + PTR_STEP) >= transfer_byte_counter; // RQ15
  assign fin     = access && at_end && !cmd_stb; // RQ14
  assign len_wr  = (s_q.mode == M_REG && s_q.code == CMD_ACK_LEN_WR && wr_stb);

  // Buffer RAM, byte lanes swapped per port
  always_ff @(posedge clk_sys) begin
    if (port_wr && is_iso) begin
      ram_even[widx] <= wr_data[15:8]; // RQ9
      ram_odd[widx]  <= wr_data[7:0];
    end else if (port_wr) begin
      ram_odd[widx]  <= wr_data[15:8]; // RQ10
      ram_even[widx] <= wr_data[7:0];
    end
  end

  // Next state
  always_comb begin
    s_d = s_q;
    s_d.eot = 1'b0;
    s_d.rb0 = iso0_pending_bytes; // RQ5
    s_d.rb1 = iso1_pending_bytes; // RQ6
    // Command decode: one code opens a run of word accesses
    if (cmd_stb) begin
      s_d.code = cmd_code;
      s_d.ptr  = '0;
      s_d.iso_sel = iso_port_sel;
      case (cmd_code)
        CMD_ISO_PORT_RD: s_d.mode = M_ISO_RD; // RQ11
        CMD_ISO_PORT_WR: s_d.mode = M_ISO_WR; // RQ11
        CMD_ACK_PORT_RD: s_d.mode = M_ACK_RD; // RQ12
        CMD_ACK_PORT_WR: s_d.mode = M_ACK_WR; // RQ12
        default:         s_d.mode = M_REG;
      endcase
    end else if (access) begin
      s_d.ptr = s_q.ptr + PTR_STEP; // RQ13
      if (at_end) begin
        s_d.eot  = 1'b1; // RQ14
        s_d.mode = M_IDLE;
      end
    end
    // Region size register write
    if (len_wr) begin
      s_d.ack_len = wr_data; // RQ1
    end
    // Status clears on end of transfer, sets from the engine win
    if (fin) begin
      case (s_q.mode)
        M_ISO_RD: s_d.flags[s_q.iso_sel ? ISO1_FULL_BIT : ISO0_FULL_BIT] = 1'b0; // RQ16
        M_ACK_RD: s_d.flags[ACK_FULL_BIT] = 1'b0; // RQ16
        M_ISO_WR: s_d.flags[s_q.iso_sel ? ISO1_DONE_BIT : ISO0_DONE_BIT] = 1'b0;
        M_ACK_WR: s_d.flags[ACK_DONE_BIT] = 1'b0;
        default:  s_d.flags = s_d.flags;
      endcase
    end
    s_d.flags[5:3] = s_d.flags[5:3] | {engine_consumed[2], engine_consumed[1], engine_consumed[0]}; // RQ3
    s_d.flags[2:0] = s_d.flags[2:0] | engine_filled; // RQ4
    // Read data for the current command
    case (s_q.mode)
      M_ISO_RD: s_d.rdata = {ram_even[widx], ram_odd[widx]}; // RQ9
      M_ACK_RD: s_d.rdata = {ram_odd[widx], ram_even[widx]}; // RQ10
      M_REG: begin
        case (s_q.code)
          CMD_ACK_LEN_RD: s_d.rdata = s_q.ack_len;
          CMD_STATUS_RD:  s_d.rdata = {10'h000, s_q.flags}; // RQ4
          CMD_RB0_RD:     s_d.rdata = s_q.rb0;
          CMD_RB1_RD:     s_d.rdata = s_q.rb1;
          default:        s_d.rdata = REG_RESET;
        endcase
      end
      default: s_d.rdata = REG_RESET;
    endcase
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      s_q <= '{mode: M_IDLE, code: 8'h00, iso_sel: 1'b0, ptr: REG_RESET,
               rdata: REG_RESET, ack_len: REG_RESET, flags: 6'h00,
               rb0: REG_RESET, rb1: REG_RESET, eot: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign rd_data                 = s_q.rdata;
  assign all_transfers_done_flag = s_q.eot;
  assign ack_list_region_size    = s_q.ack_len;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  // Region size register: written only by its own command
  a_len_write: assert property ( // RQ1
    len_wr |=> ack_list_region_size == $past(wr_data)) else $error("size write lost");
  a_len_hold: assert property ( // RQ1
    !len_wr |=> $stable(ack_list_region_size)) else $error("size changed unasked");

  // Status flags: engine sets win, end of transfer clears
  a_done_set: assert property ( // RQ3
    engine_consumed[2] |=> s_q.flags[ACK_DONE_BIT]) else $error("ack done not set");
  a_iso1_done_set: assert property ( // RQ3
    engine_consumed[1] |=> s_q.flags[ISO1_DONE_BIT]) else $error("iso1 done not set");
  a_iso0_done_set: assert property ( // RQ3
    engine_consumed[0] |=> s_q.flags[ISO0_DONE_BIT]) else $error("iso0 done not set");
  a_full_set: assert property ( // RQ4
    engine_filled[0] |=> s_q.flags[ISO0_FULL_BIT]) else $error("iso0 full not set");
  a_iso1_full_set: assert property ( // RQ4
    engine_filled[1] |=> s_q.flags[ISO1_FULL_BIT]) else $error("iso1 full not set");
  a_ack_full_set: assert property ( // RQ4
    engine_filled[2] |=> s_q.flags[ACK_FULL_BIT]) else $error("ack full not set");
  a_status_hold: assert property ( // RQ4
    (!fin && engine_consumed == 3'b000 && engine_filled == 3'b000)
    |=> $stable(s_q.flags)) else $error("status changed unasked");
  a_status_reserved: assert property ( // RQ4
    (s_q.mode == M_REG && s_q.code == CMD_STATUS_RD)
    |=> rd_data[15:6] == 10'h000) else $error("reserved bits set");
  a_ack_empty: assert property ( // RQ16
    (fin && s_q.mode == M_ACK_RD && !engine_filled[2])
    |=> !s_q.flags[ACK_FULL_BIT]) else $error("ack full not cleared");
  a_iso_empty: assert property ( // RQ16
    (fin && s_q.mode == M_ISO_RD && !engine_filled[s_q.iso_sel])
    |=> !s_q.flags[s_q.iso_sel ? ISO1_FULL_BIT : ISO0_FULL_BIT]) else $error("iso full kept");
  a_ack_wr_clear: assert property ( // RQ16
    (fin && s_q.mode == M_ACK_WR && !engine_consumed[2])
    |=> !s_q.flags[ACK_DONE_BIT]) else $error("ack done not cleared");

  // Read-back counts follow the engine one cycle late
  a_rb0_track: assert property ( // RQ5
    s_q.rb0 == $past(iso0_pending_bytes) || !$past(resetn)) else $error("iso0 count stale");
  a_rb1_track: assert property ( // RQ6
    s_q.rb1 == $past(iso1_pending_bytes) || !$past(resetn)) else $error("iso1 count stale");

  // Pointer, end of transfer and idle behaviour
  a_ptr_clear: assert property ( // RQ13
    cmd_stb |=> s_q.ptr == REG_RESET) else $error("pointer not cleared");
  a_ptr_step: assert property ( // RQ13
    (access && !at_end && !cmd_stb)
    |=> s_q.ptr == $past(s_q.ptr) + PTR_STEP) else $error("pointer step wrong");
  a_eot_end: assert property ( // RQ14
    fin |=> all_transfers_done_flag ##1 !all_transfers_done_flag) else $error("no eot");
  a_eot_cause: assert property ( // RQ14
    all_transfers_done_flag |-> $past(fin)) else $error("spurious eot");
  a_idle_hold: assert property ( // RQ14
    (s_q.mode == M_IDLE && !cmd_stb) |=> s_q.mode == M_IDLE) else $error("left idle");
  a_rd_idle: assert property ( // RQ14
    (s_q.mode == M_IDLE) |=> rd_data == REG_RESET) else $error("idle read data");

  // Byte lanes of the two ports
  a_iso_order: assert property ( // RQ9
    (s_q.mode == M_ISO_RD) ##1 (s_q.mode == M_ISO_RD && $stable(widx))
    |-> rd_data == {ram_even[widx], ram_odd[widx]}) else $error("iso byte order");
  a_ack_order: assert property ( // RQ10
    (s_q.mode == M_ACK_RD) ##1 (s_q.mode == M_ACK_RD && $stable(widx))
    |-> rd_data == {ram_odd[widx], ram_even[widx]}) else $error("ack byte order");

  // Main scenarios reached
  c_iso_write: cover property (s_q.mode == M_ISO_WR ##[1:20] all_transfers_done_flag);
  c_iso_read: cover property (s_q.mode == M_ISO_RD ##[1:20] all_transfers_done_flag);
  c_ack_read: cover property (s_q.mode == M_ACK_RD ##[1:20] all_transfers_done_flag);
  c_ack_write: cover property (s_q.mode == M_ACK_WR ##[1:20] all_transfers_done_flag);
  c_status_rd: cover property (s_q.mode == M_REG && s_q.code == CMD_STATUS_RD && s_q.flags != 6'h00);
endmodule // host_buffer_ram_access
`default_nettype wire

// *** rtl/buf_ram_pkg.sv ***
// Constants and types for the host buffer RAM access block
// Functional notes
// RQ1 - 16-bit read/write ack-list region size register, reset zero
// RQ2 - Software keeps ack-list size plus twice iso size within 4096 bytes
// RQ3 - Status bits 5,4,3 report ack-list, iso1, iso0 buffer read-done
// RQ4 - Status bits 2,1,0 report full; read-only, reset zero, 15..6 reserved
// RQ5 - Read-only register shows bytes pending read-back in iso buffer zero
// RQ6 - Read-only register shows bytes pending read-back in iso buffer one
// RQ7 - Software loads byte counter from read-back count before iso read-back
// RQ8 - Software loads byte counter and checks status before port access
// RQ9 - Iso port: even byte on bits 15..8, odd byte on 7..0
// RQ10 - Ack-list port: odd byte on bits 15..8, even byte on 7..0
// RQ11 - Iso port command 40H read or C0H write issued once, then words
// RQ12 - Ack-list port command 41H read or C1H write issued once, then words
// RQ13 - Each port word access advances the buffer pointer by two bytes
// RQ14 - Pointer reaching byte count raises end-of-transfer event, updating status
// RQ15 - Counter holds bytes while the port moves words, two bytes each
// RQ16 - Engine consumption sets read-done; emptied buffer clears its full flag
package buf_ram_pkg;
  // ----------------------------------------------------------------
  // Command codes (read code, write code = read code with bit 7 set)
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_ACK_LEN_RD  = 8'h2B;
  localparam logic [7:0] CMD_ACK_LEN_WR  = 8'hAB;
  localparam logic [7:0] CMD_STATUS_RD   = 8'h2C;
  localparam logic [7:0] CMD_RB0_RD      = 8'h2D;
  localparam logic [7:0] CMD_RB1_RD      = 8'h2E;
  localparam logic [7:0] CMD_ISO_PORT_RD = 8'h40;
  localparam logic [7:0] CMD_ISO_PORT_WR = 8'hC0;
  localparam logic [7:0] CMD_ACK_PORT_RD = 8'h41;
  localparam logic [7:0] CMD_ACK_PORT_WR = 8'hC1;
  // ----------------------------------------------------------------
  // Status field positions and reset values
  // ----------------------------------------------------------------
  localparam int ACK_DONE_BIT = 5;
  localparam int ISO1_DONE_BIT = 4;
  localparam int ISO0_DONE_BIT = 3;
  localparam int ACK_FULL_BIT = 2;
  localparam int ISO1_FULL_BIT = 1;
  localparam int ISO0_FULL_BIT = 0;
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [15:0] PTR_STEP  = 16'h0002;
  localparam int RAM_BYTES = 4096;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    M_IDLE, M_REG, M_ISO_RD, M_ISO_WR, M_ACK_RD, M_ACK_WR
  } mode_t;
endpackage

// *** sim/cpu_model.sv ***
// Processor-side model: issues commands and moves port words
`timescale 1ns/1ps
`default_nettype none
module cpu_model (
  // Clock
  input  wire logic        clk_sys,
  // Command and data strobes
  output var  logic        cmd_stb,
  output var  logic [7:0]  cmd_code,
  output var  logic        wr_stb,
  output var  logic [15:0] wr_data,
  output var  logic        rd_stb
);
  initial {cmd_stb, cmd_code, wr_stb, wr_data, rd_stb} = '0;
  // Command code once per transfer, then words only
  task automatic cmd(input logic [7:0] c);
    @(posedge clk_sys);
    cmd_stb  <= 1'b1;
    cmd_code <= c;
    @(posedge clk_sys);
    cmd_stb  <= 1'b0;
    cmd_code <= ~c; // Released line never keeps the old code
    repeat (2) @(posedge clk_sys);
  endtask
  // One word per strobe, strobes kept apart by the answer delay
  task automatic word(input logic wr, input logic [15:0] d);
    @(posedge clk_sys);
    wr_stb  <= wr;
    rd_stb  <= !wr;
    wr_data <= d;
    @(posedge clk_sys);
    wr_stb  <= 1'b0;
    rd_stb  <= 1'b0;
    wr_data <= ~d;
    repeat (2) @(posedge clk_sys);
  endtask
endmodule // cpu_model
`default_nettype wire

// *** sim/tb_top.sv ***
// Self-checking bench for the host buffer RAM access block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import buf_ram_pkg::*;
  logic        clk_sys = 1'b0, resetn = 1'b0, iso_port_sel = 1'b0;
  logic [15:0] transfer_byte_counter = '0, iso_region_size = '0, sz;
  logic [15:0] iso0_pending_bytes = '0, iso1_pending_bytes = '0;
  logic [2:0]  engine_consumed = '0, engine_filled = '0;
  logic [5:0]  st = '0;
  logic [7:0]  mem [0:4095];
  wire         cmd_stb, wr_stb, rd_stb, all_transfers_done_flag;
  wire  [7:0]  cmd_code;
  wire  [15:0] wr_data, rd_data, ack_list_region_size;
  int          miscompares = 0, cmp_count = 0, eot_cnt = 0, cyc = 0;
  always #20 clk_sys = ~clk_sys;
  cpu_model i_cpu_model (.clk_sys, .cmd_stb, .cmd_code, .wr_stb, .wr_data, .rd_stb);
  host_buffer_ram_access i_host_buffer_ram_access (.clk_sys, .resetn, .cmd_stb, .cmd_code,
    .wr_stb, .wr_data, .rd_stb, .rd_data, .transfer_byte_counter, .iso_region_size,
    .iso_port_sel, .iso0_pending_bytes, .iso1_pending_bytes, .engine_consumed,
    .engine_filled, .all_transfers_done_flag, .ack_list_region_size);
  // Count end-of-transfer pulses and cut a hang short
  always @(posedge clk_sys) begin
    cyc++;
    if (all_transfers_done_flag === 1'b1) eot_cnt++;
    if (cyc == 5000) begin
      miscompares++;
      final_report();
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rdchk(input logic [7:0] c, input logic [15:0] exp, input string what);
    i_cpu_model.cmd(c);
    #1 chk(rd_data, exp, what);
    @(posedge clk_sys);
  endtask
  task automatic eng(input int i, input bit fill);
    @(posedge clk_sys);
    if (fill) engine_filled[i] <= 1'b1;
    else engine_consumed[i] <= 1'b1;
    @(posedge clk_sys);
    {engine_filled, engine_consumed} <= '0;
  endtask
  // ------------------------------------------------------------
  // Port transfer against a byte model; all regions start at 0
  // ------------------------------------------------------------
  task automatic xfer(input logic [7:0] c, input int n);
    int k, base, fb;
    logic [15:0] d, e;
    logic wr, iso;
    wr = c[7];
    iso = !c[0];
    k = (n + 1) / 2;
    base = eot_cnt;
    transfer_byte_counter <= 16'(n);
    i_cpu_model.cmd(c);
    fb = iso ? int'(iso_port_sel) : 2;
    for (int j = 0; j < k; j++) begin
      d = 16'($urandom);
      e = iso ? {mem[2*j], mem[2*j+1]} : {mem[2*j+1], mem[2*j]};
      if (!wr) #1 chk(rd_data, e, "port word");
      if (wr && iso) {mem[2*j], mem[2*j+1]} = d;
      if (wr && !iso) {mem[2*j+1], mem[2*j]} = d;
      chk(16'(eot_cnt - base), 16'h0000, "early end");
      i_cpu_model.word(wr, d);
    end
    i_cpu_model.word(wr, d);
    chk(16'(eot_cnt - base), 16'h0001, "end count");
    st[wr ? fb + 3 : fb] = 1'b0;
    rdchk(CMD_STATUS_RD, {10'h000, st}, "status end");
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    sz = 16'($urandom(4) % (RAM_BYTES + 1));
    repeat (10) @(posedge clk_sys);
    resetn <= 1'b1;
    rdchk(CMD_ACK_LEN_RD, REG_RESET, "size reset");
    rdchk(CMD_STATUS_RD, REG_RESET, "status reset");
    iso0_pending_bytes <= 16'($urandom);
    iso1_pending_bytes <= 16'($urandom);
    i_cpu_model.cmd(CMD_ACK_LEN_WR);
    i_cpu_model.word(1'b1, sz);
    rdchk(CMD_ACK_LEN_RD, sz, "size");
    chk(ack_list_region_size, sz, "size out");
    rdchk(CMD_RB0_RD, iso0_pending_bytes, "pending 0");
    rdchk(CMD_RB1_RD, iso1_pending_bytes, "pending 1");
    for (int i = 0; i < 3; i++) begin
      eng(i, 1'b1);
      st[i] = 1'b1;
      eng(i, 1'b0);
      st[i + 3] = 1'b1;
      rdchk(CMD_STATUS_RD, {10'h000, st}, "status set");
    end
    i_cpu_model.word(1'b1, 16'hFFFF);
    rdchk(CMD_STATUS_RD, {10'h000, st}, "status ro");
    iso_port_sel <= 1'($urandom);
    xfer(CMD_ISO_PORT_WR, 6);
    xfer(CMD_ACK_PORT_RD, 6);
    xfer(CMD_ACK_PORT_WR, 5);
    iso0_pending_bytes <= 16'h0005;
    iso1_pending_bytes <= 16'h0005;
    rdchk(iso_port_sel ? CMD_RB1_RD : CMD_RB0_RD, 16'h0005, "read-back len");
    xfer(CMD_ISO_PORT_RD, 5);
    final_report();
  end
endmodule // tb_top
`default_nettype wire
